// ==== inc/acc_pkg.sv ====
// constants and state types for the analog comparator control block
// Overview of operation
// RULE1 - the enable bit at position 7 turns the comparator function on when 1 and off when 0.
// RULE2 - the reference select bit at position 6 picks the external pin at 0, the bandgap at 1.
// RULE3 - the comparator result is 1 when the non-inverting input exceeds the inverting one.
// RULE4 - the event flag at bit 5 is set by hardware on each event of the selected mode.
// RULE5 - writing a one to bit 5 clears the event flag.
// RULE6 - with the interrupt enable at bit 4 set, an interrupt stands while the flag is set.
// RULE7 - reading the output bit at position 3 returns the present comparator result.
// RULE8 - the output bit resets to zero and reads zero while the enable bit is clear.
// RULE9 - with the pin enable at bit 2 set the result is driven on the output pin, else not.
// RULE10 - the mode field 1:0 picks falling (00, 10), rising (01) or either edge (11).
// RULE11 - in shallow stop events still set the flag and an enabled event wakes the processor.
// RULE12 - leaving deep stop, or any stop through reset, returns every field to reset state.
// RULE13 - the raw comparator result passes two flip-flops before edge detection and reads.
// RULE14 - writing zero to the flag leaves it alone; no edge is seen while disabled.
package acc_pkg;
    localparam logic [1:0] ADDR_SC = 2'h0;
    localparam int BIT_EN = 7;
    localparam int BIT_REF = 6;
    localparam int BIT_FLAG = 5;
    localparam int BIT_IE = 4;
    localparam int BIT_OUT = 3;
    localparam int BIT_OPE = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [1:0] MODE_FALL0 = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL2 = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;

    typedef struct packed {
        logic en;
        logic ref_sel;
        logic flag;
        logic ie;
        logic ope;
        logic [1:0] mode;
        logic [7:0] rdata;
        logic irq;
        logic pin;
        logic pin_oe_n;
        logic wake;
    } acc_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [2:0] en_pipe;
    } acc_sync_t;
endpackage

// ==== inc/acc_edge_if.sv ====
// synchronised comparator level and its edges, between edge unit and control
`timescale 1ns/10ps
interface acc_edge_if;
    logic enable;
    logic level;
    logic rise;
    logic fall;
    modport edge_src (input enable, output level, output rise, output fall);
    modport edge_use (output enable, input level, input rise, input fall);
endinterface

// ==== rtl/acc_edge.sv ====
// two-stage synchroniser and edge detector for the raw comparator result
`timescale 1ns/10ps
module acc_edge (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // raw result from the analog core
    input wire logic cmp_raw,
    // towards the control logic
    acc_edge_if.edge_src eif
);
    acc_pkg::acc_sync_t st_r;
    acc_pkg::acc_sync_t st_nxt;
    logic edge_ok;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = cmp_raw; // [RULE13]
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.en_pipe = {st_r.en_pipe[1:0], eif.enable};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // an unpowered core gives no trustworthy level, so an edge only counts once every
    // sample behind it was taken while enabled; switching on never fakes an edge
    assign edge_ok = eif.enable & (&st_r.en_pipe); // [RULE14]
    assign eif.level = st_r.s2;
    assign eif.rise = edge_ok & st_r.s2 & ~st_r.s3; // [RULE14]
    assign eif.fall = edge_ok & ~st_r.s2 & st_r.s3; // [RULE14]

    chk_edge_gate: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        !eif.enable |-> !(eif.rise || eif.fall))
        else $error("edge seen while disabled");
    chk_sync_depth: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        eif.rise |-> $past(cmp_raw, 2) && !$past(cmp_raw, 3))
        else $error("rise not two stages after raw change");
    chk_enable_settle: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        $rose(eif.enable) |-> (!(eif.rise || eif.fall))[*3])
        else $error("edge reported before the core settled");
endmodule

// ==== rtl/acc_ctrl.sv ====
// status/control register, event flag, interrupt, wake and pin drive of the comparator
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
module acc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog core
    input wire logic cmp_raw,
    output logic comparator_enable,
    output logic reference_select,
    // pin
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe_n,
    // power management
    input wire logic stop_shallow,
    input wire logic deep_stop_exit,
    output logic wake_req,
    // interrupt
    output logic irq
);
    acc_pkg::acc_state_t st_r;
    acc_pkg::acc_state_t st_nxt;
    acc_edge_if eif ();
    logic wr_sc;
    logic rd_sc;
    logic event_hit;
    logic out_bit;

    // register image as software reads it; the output bit arrives already gated
    function automatic logic [7:0] sc_image(input acc_pkg::acc_state_t s, input logic out_b);
        logic [7:0] img;
        img = 8'h00;
        img[acc_pkg::BIT_EN] = s.en;
        img[acc_pkg::BIT_REF] = s.ref_sel;
        img[acc_pkg::BIT_FLAG] = s.flag;
        img[acc_pkg::BIT_IE] = s.ie;
        img[acc_pkg::BIT_OUT] = out_b; // [RULE7] [RULE8]
        img[acc_pkg::BIT_OPE] = s.ope;
        img[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO] = s.mode;
        return img;
    endfunction

    // every software field back to its reset value, with no read data standing
    function automatic acc_pkg::acc_state_t sc_restore(input acc_pkg::acc_state_t s);
        acc_pkg::acc_state_t r;
        r = s;
        r.en = acc_pkg::SC_RESET[acc_pkg::BIT_EN];
        r.ref_sel = acc_pkg::SC_RESET[acc_pkg::BIT_REF];
        r.flag = acc_pkg::SC_RESET[acc_pkg::BIT_FLAG];
        r.ie = acc_pkg::SC_RESET[acc_pkg::BIT_IE];
        r.ope = acc_pkg::SC_RESET[acc_pkg::BIT_OPE];
        r.mode = acc_pkg::SC_RESET[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];
        r.rdata = 8'h00;
        return r;
    endfunction

    acc_edge u_edge (
        .clk(clk),
        .resetn(resetn),
        .cmp_raw(cmp_raw),
        .eif(eif)
    );

    // the analog core drives high when non-inverting exceeds inverting
    assign out_bit = st_r.en & eif.level; // [RULE3] [RULE8]
    assign eif.enable = st_r.en; // [RULE1]
    assign wr_sc = reg_wr && (reg_addr == acc_pkg::ADDR_SC);
    assign rd_sc = reg_rd && (reg_addr == acc_pkg::ADDR_SC);

    always_comb begin
        case (st_r.mode)
            acc_pkg::MODE_RISE: event_hit = eif.rise; // [RULE10]
            acc_pkg::MODE_BOTH: event_hit = eif.rise | eif.fall; // [RULE10]
            acc_pkg::MODE_FALL0, acc_pkg::MODE_FALL2: event_hit = eif.fall; // [RULE10]
            default: event_hit = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        if (wr_sc) begin
            st_nxt.en = reg_wdata[acc_pkg::BIT_EN]; // [RULE1]
            st_nxt.ref_sel = reg_wdata[acc_pkg::BIT_REF]; // [RULE2]
            st_nxt.ie = reg_wdata[acc_pkg::BIT_IE];
            st_nxt.ope = reg_wdata[acc_pkg::BIT_OPE];
            st_nxt.mode = reg_wdata[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];
            // a zero in the flag position leaves the flag as it was
            if (reg_wdata[acc_pkg::BIT_FLAG]) begin
                st_nxt.flag = 1'b0; // [RULE5] [RULE14]
            end
        end
        // set after clear so an event in the clearing cycle is kept
        if (event_hit) begin
            st_nxt.flag = 1'b1; // [RULE4] [RULE11]
        end
        st_nxt.rdata = 8'h00;
        if (rd_sc) begin
            st_nxt.rdata = sc_image(st_r, out_bit); // [RULE7] [RULE8]
        end
        // deep stop powers the analog part down, so everything returns to reset
        if (deep_stop_exit) begin
            st_nxt = sc_restore(st_nxt); // [RULE12]
        end
        st_nxt.irq = st_nxt.flag & st_nxt.ie; // [RULE6]
        st_nxt.wake = stop_shallow & event_hit & st_r.ie & ~deep_stop_exit; // [RULE11]
        st_nxt.pin_oe_n = ~st_nxt.ope; // [RULE9]
        st_nxt.pin = st_nxt.ope & st_nxt.en & eif.level; // [RULE9]
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.pin_oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign comparator_enable = st_r.en;
    assign reference_select = st_r.ref_sel;
    assign comparator_out_pin = st_r.pin;
    assign comparator_out_pin_oe_n = st_r.pin_oe_n;
    assign wake_req = st_r.wake;
    assign irq = st_r.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_flag_event_set: assert property ( // [RULE4]
        event_hit && !deep_stop_exit |=> st_r.flag)
        else $error("event did not set flag");
    chk_flag_write_clear: assert property ( // [RULE5]
        wr_sc && reg_wdata[acc_pkg::BIT_FLAG] && !event_hit |=> !st_r.flag)
        else $error("write one did not clear flag");
    chk_flag_zero_hold: assert property ( // [RULE14]
        wr_sc && !reg_wdata[acc_pkg::BIT_FLAG] && st_r.flag && !deep_stop_exit |=> st_r.flag)
        else $error("write zero changed flag");
    chk_irq_follows_flag: assert property ( // [RULE6]
        irq == (st_r.flag && st_r.ie))
        else $error("interrupt differs from flag and enable");
    chk_out_bit_read: assert property ( // [RULE7]
        rd_sc && !deep_stop_exit |=> reg_rdata[acc_pkg::BIT_OUT] == $past(out_bit))
        else $error("output bit read wrong");
    chk_out_bit_off: assert property ( // [RULE8]
        rd_sc && !st_r.en |=> !reg_rdata[acc_pkg::BIT_OUT])
        else $error("output bit nonzero while disabled");
    chk_pin_drive: assert property ( // [RULE9]
        comparator_out_pin_oe_n == !st_r.ope && (st_r.ope || !comparator_out_pin))
        else $error("pin drive does not follow pin enable");
    chk_mode_rise_only: assert property ( // [RULE10]
        st_r.mode == acc_pkg::MODE_RISE && eif.fall && !st_r.flag && !wr_sc |=> !st_r.flag)
        else $error("falling edge set flag in rising mode");
    chk_disabled_quiet: assert property ( // [RULE1]
        !st_r.en && !st_r.flag && !wr_sc ##1 !st_r.en |-> !st_r.flag)
        else $error("flag set while disabled");
    chk_wake_event: assert property ( // [RULE11]
        stop_shallow && event_hit && st_r.ie && !deep_stop_exit |=> wake_req && st_r.flag)
        else $error("shallow stop event did not wake");
    chk_deep_reset: assert property ( // [RULE12]
        deep_stop_exit |=> !st_r.en && !st_r.flag && !irq && st_r.mode == 2'h0)
        else $error("deep stop exit did not reset fields");
    chk_ref_write: assert property ( // [RULE2]
        wr_sc && !deep_stop_exit |=> reference_select == $past(reg_wdata[acc_pkg::BIT_REF]))
        else $error("reference select not written");
    chk_en_write: assert property ( // [RULE1]
        wr_sc && !deep_stop_exit |=> comparator_enable == $past(reg_wdata[acc_pkg::BIT_EN]))
        else $error("enable bit not written");
    chk_ie_write: assert property ( // [RULE6]
        wr_sc && !deep_stop_exit |=> st_r.ie == $past(reg_wdata[acc_pkg::BIT_IE]))
        else $error("interrupt enable not written");
    chk_ope_write: assert property ( // [RULE9]
        wr_sc && !deep_stop_exit |=> comparator_out_pin_oe_n == !$past(reg_wdata[acc_pkg::BIT_OPE]))
        else $error("pin enable not written");
    chk_mode_write: assert property ( // [RULE10]
        wr_sc && !deep_stop_exit
        |=> st_r.mode == $past(reg_wdata[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO]))
        else $error("event mode not written");
    chk_fields_hold: assert property ( // [RULE1]
        !wr_sc && !deep_stop_exit |=> $stable({st_r.en, st_r.ref_sel, st_r.ie, st_r.ope, st_r.mode}))
        else $error("control field changed without a write");
    chk_flag_sticky: assert property ( // [RULE4]
        st_r.flag && !(wr_sc && reg_wdata[acc_pkg::BIT_FLAG]) && !deep_stop_exit |=> st_r.flag)
        else $error("flag dropped without a clear");
    chk_flag_no_cause: assert property ( // [RULE4]
        !st_r.flag && !event_hit |=> !st_r.flag)
        else $error("flag set without an event");
    chk_flag_read: assert property ( // [RULE4]
        rd_sc && !deep_stop_exit |=> reg_rdata[acc_pkg::BIT_FLAG] == $past(st_r.flag))
        else $error("flag read wrong");
    chk_rdata_idle: assert property ( // [RULE7]
        !rd_sc |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_read_ctrl: assert property ( // [RULE7]
        rd_sc && !deep_stop_exit |=> reg_rdata[acc_pkg::BIT_EN] == $past(st_r.en)
        && reg_rdata[acc_pkg::BIT_IE] == $past(st_r.ie) && reg_rdata[acc_pkg::BIT_OPE] == $past(st_r.ope))
        else $error("control bits read wrong");
    chk_irq_masked: assert property ( // [RULE6]
        !st_r.ie |-> !irq)
        else $error("interrupt raised while masked");
    chk_mode_fall_only: assert property ( // [RULE10]
        (st_r.mode == acc_pkg::MODE_FALL0 || st_r.mode == acc_pkg::MODE_FALL2) && eif.rise
        && !st_r.flag && !wr_sc |=> !st_r.flag)
        else $error("rising edge set flag in falling mode");
    chk_mode_both_edges: assert property ( // [RULE10]
        st_r.mode == acc_pkg::MODE_BOTH && (eif.rise || eif.fall) && !deep_stop_exit |=> st_r.flag)
        else $error("edge missed in either-edge mode");
    chk_wake_needs_stop: assert property ( // [RULE11]
        !stop_shallow |=> !wake_req)
        else $error("wake outside shallow stop");
    chk_wake_needs_ie: assert property ( // [RULE11]
        !st_r.ie |=> !wake_req)
        else $error("wake with interrupt disabled");
    chk_pin_level: assert property ( // [RULE9]
        st_r.ope && st_r.en && !wr_sc && !deep_stop_exit |=> comparator_out_pin == $past(eif.level))
        else $error("pin does not follow result");
    chk_pin_off_disabled: assert property ( // [RULE9]
        !st_r.en |-> !comparator_out_pin)
        else $error("pin high while disabled");
    chk_deep_clears_cfg: assert property ( // [RULE12]
        deep_stop_exit |=> !reference_select && !st_r.ie && comparator_out_pin_oe_n && !wake_req)
        else $error("deep stop exit left configuration");
    chk_out_bit_live: assert property ( // [RULE3]
        rd_sc && st_r.en && !deep_stop_exit |=> reg_rdata[acc_pkg::BIT_OUT] == $past(eif.level))
        else $error("output bit does not show result");

    cov_rise_flag: cover property (st_r.mode == acc_pkg::MODE_RISE && eif.rise ##1 st_r.flag);
    cov_both_irq: cover property (st_r.mode == acc_pkg::MODE_BOTH && event_hit ##1 irq);
    cov_set_beats_clear: cover property (wr_sc && reg_wdata[acc_pkg::BIT_FLAG] && event_hit);
    cov_wake: cover property (wake_req);
    cov_fall2_flag: cover property (st_r.mode == acc_pkg::MODE_FALL2 && eif.fall ##1 st_r.flag);
endmodule

// ==== dv/acc_analog_model.sv ====
// behavioural analog core: source select and compare
`timescale 1ns/10ps
module acc_analog_model (
    // control from the block
    input wire logic comparator_enable,
    input wire logic reference_select,
    // analog levels as codes
    input wire logic [7:0] noninverting_input,
    input wire logic [7:0] inverting_input,
    input wire logic [7:0] bandgap_level,
    // raw result
    output logic cmp_raw
);
    logic [7:0] pos_sel;
    logic gt;
    assign pos_sel = reference_select ? bandgap_level : noninverting_input;
    assign gt = pos_sel > inverting_input;
    // an unpowered core gives no trustworthy level, so show the wrong one
    assign cmp_raw = comparator_enable ? gt : ~gt;
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic stop_shallow = 1'b0;
    logic deep_stop_exit = 1'b0;
    logic [7:0] vpos = 8'h40;
    logic [7:0] vneg = 8'h80;
    logic [7:0] vbg = 8'hc0;
    logic cmp_raw, comp_en, ref_sel, pin, pin_oe_n, wake_req, irq;
    logic [7:0] reg_rdata;
    logic [7:0] v;
    int n_mismatch = 0;
    int checks_done = 0;
    int k;
    always #12.5 clk = ~clk;
    acc_ctrl uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
        .comparator_enable(comp_en), .reference_select(ref_sel),
        .comparator_out_pin(pin), .comparator_out_pin_oe_n(pin_oe_n),
        .stop_shallow(stop_shallow), .deep_stop_exit(deep_stop_exit),
        .wake_req(wake_req), .irq(irq));
    acc_analog_model model (.comparator_enable(comp_en), .reference_select(ref_sel),
        .noninverting_input(vpos), .inverting_input(vneg), .bandgap_level(vbg),
        .cmp_raw(cmp_raw));
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_reg(input string what, input logic [7:0] exp);
        rd(2'h0, v);
        cmp(what, exp, v);
    endtask
    // sync chain plus flag takes three edges; six leaves margin
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic set_pos(input logic [7:0] lvl);
        @(posedge clk);
        vpos <= lvl;
    endtask
    task automatic t_reset_and_map();
        chk_reg("reset value", 8'h00);
        cmp("oe_n at reset", 8'h01, {7'h0, pin_oe_n});
        wr(2'h1, 8'hff);
        chk_reg("after unmapped write", 8'h00);
        rd(2'h2, v);
        cmp("unmapped read", 8'h00, v);
    endtask
    task automatic t_modes();
        logic [1:0] m;
        logic f;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            set_pos(8'h40);
            wr(2'h0, 8'h94 | m);
            settle();
            wr(2'h0, 8'hb4 | m);
            chk_reg("armed", 8'h94 | m);
            set_pos(8'hc0);
            settle();
            chk_reg("after rise", 8'h9c | m | {2'h0, m[0], 5'h0});
            cmp("irq after rise", {7'h0, m[0]}, {7'h0, irq});
            cmp("pin drive", 8'h02, {6'h0, pin, pin_oe_n});
            wr(2'h0, 8'hb4 | m);
            set_pos(8'h40);
            settle();
            f = (m != 2'h1);
            chk_reg("after fall", 8'h94 | m | {2'h0, f, 5'h0});
        end
        wr(2'h0, 8'h83);
        chk_reg("write zero keeps flag", 8'ha3);
        cmp("irq masked, pin off", 8'h01, {5'h0, irq, pin, pin_oe_n});
    endtask
    task automatic t_disable_and_ref();
        wr(2'h0, 8'h23);
        set_pos(8'hc0);
        settle();
        chk_reg("disabled", 8'h03);
        set_pos(8'h40);
        wr(2'h0, 8'hc0);
        settle();
        rd(2'h0, v);
        cmp("bandgap compare", 8'h48, v & 8'h48);
        @(posedge clk);
        #1 cmp("read data after its cycle", 8'h00, reg_rdata);
        cmp("core controls", 8'h03, {6'h0, comp_en, ref_sel});
    endtask
    task automatic t_mid_reset();
        wr(2'h0, 8'hd7);
        settle();
        chk_reg("no edge on enable", 8'hdf);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 cmp("outputs after reset", 8'h04, {4'h0, irq, pin_oe_n, comp_en, ref_sel});
        chk_reg("after mid-run reset", 8'h00);
    endtask
    task automatic t_wake_and_deep();
        wr(2'h0, 8'hb3);
        settle();
        wr(2'h0, 8'hb3);
        @(posedge clk);
        stop_shallow <= 1'b1;
        vpos <= 8'hc0;
        k = 0;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 if (wake_req === 1'b1) k++;
        end
        cmp("wake pulses", 8'h01, k[7:0]);
        chk_reg("flag in stop", 8'hbb);
        @(posedge clk);
        stop_shallow <= 1'b0;
        deep_stop_exit <= 1'b1;
        @(posedge clk);
        deep_stop_exit <= 1'b0;
        chk_reg("deep stop exit", 8'h00);
        cmp("irq after exit", 8'h00, {7'h0, irq});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset_and_map();
        t_modes();
        t_disable_and_ref();
        t_wake_and_deep();
        t_mid_reset();
        summarize();
    end
endmodule
